//--- logic/obd_readback.sv
// octal converter register file with readback command decoder
// assumes a serial front end on clk_in that hands over whole bytes
`timescale 1ns/1ps
`include "obd_defs.svh"

module obd_readback
  import obd_pkg::*;
#(
  parameter int CODE_BITS = `OBD_CODE_BITS
)(
  input  wire logic                              clk_in,
  input  wire logic                              rst_in,
  input  wire logic                              cmd_valid_in,
  input  wire logic [7:0]                        cmd_byte_in,
  input  wire logic                              rd_req_in,
  output logic      [7:0]                        rd_data_out,
  output logic                                   rd_valid_out,
  output logic                                   invalid_out,
  input  wire logic                              wr_valid_in,
  input  wire logic [7:0]                        wr_cmd_in,
  input  wire logic [15:0]                       wr_data_in,
  input  wire logic                              load_trigger_pin_n_in,
  input  wire logic                              clear_pin_n_in,
  output logic      [`OBD_NUM_CH*`OBD_STORE_BITS-1:0] active_code_out,
  output logic      [1:0]                        power_mode_out,
  output logic      [7:0]                        power_sel_out
);

  // ********************************
  // helpers
  // ********************************
  localparam int SHIFT = `OBD_STORE_BITS - CODE_BITS;

  // left-justify the code; bits below it read zero
  function automatic logic [15:0] pack_code(input obd_code_t code);
    obd_code_t left;
    left = obd_code_t'(code << SHIFT);
    return {left, 4'h0};
  endfunction

  function automatic obd_code_t unpack_code(input logic [15:0] data);
    return obd_code_t'(data[15:4] >> SHIFT);
  endfunction

  function automatic obd_code_t clear_value(input logic [1:0] sel);
    obd_code_t full;
    full = obd_code_t'({`OBD_STORE_BITS{1'b1}} >> SHIFT);
    if (sel == `OBD_CLR_MID) begin
      return obd_code_t'(full ^ (full >> 1));
    end else if (sel == `OBD_CLR_FULL) begin
      return full;
    end else begin
      return `OBD_CODE_RST;
    end
  endfunction

  // ********************************
  // pin edges
  // ********************************
  logic load_fall;
  logic clr_fall;

  obd_pin_fall u_load_fall (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pin_n_in (load_trigger_pin_n_in),
    .fall_out (load_fall)
  );

  obd_pin_fall u_clr_fall (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .pin_n_in (clear_pin_n_in),
    .fall_out (clr_fall)
  );

  // ********************************
  // register file
  // ********************************
  obd_code_t  buf_ff  [`OBD_NUM_CH];
  obd_code_t  act_ff  [`OBD_NUM_CH];
  obd_code_t  nxt_buf [`OBD_NUM_CH];
  obd_code_t  nxt_act [`OBD_NUM_CH];
  logic [1:0] pd_mode_ff;
  logic [7:0] pd_sel_ff;
  logic [1:0] clr_sel_ff;
  logic [7:0] ovr_ff;
  logic [1:0] nxt_pd_mode;
  logic [7:0] nxt_pd_sel;
  logic [1:0] nxt_clr_sel;
  logic [7:0] nxt_ovr;
  logic [3:0] wr_op;
  logic [2:0] wr_ch;

  assign wr_op = wr_cmd_in[7:4];
  assign wr_ch = wr_cmd_in[2:0];

  always_comb begin
    nxt_buf     = buf_ff;
    nxt_act     = act_ff;
    nxt_pd_mode = pd_mode_ff;
    nxt_pd_sel  = pd_sel_ff;
    nxt_clr_sel = clr_sel_ff;
    nxt_ovr     = ovr_ff;
    if (load_fall) begin
      for (int i = 0; i < `OBD_NUM_CH; i++) begin
        if (!ovr_ff[i]) begin
          nxt_act[i] = buf_ff[i];
        end
      end
    end
    if (wr_valid_in) begin
      if (wr_op == `OBD_CMD_INPUT && !wr_cmd_in[3]) begin
        nxt_buf[wr_ch] = unpack_code(wr_data_in);
      end else if (wr_op == `OBD_CMD_ACTIVE && !wr_cmd_in[3]) begin
        // software update path for overridden channels, which otherwise change only on the clear pin and the reset opcode
        nxt_buf[wr_ch] = unpack_code(wr_data_in);
        nxt_act[wr_ch] = unpack_code(wr_data_in);
      end else if (wr_op == `OBD_CMD_POWER) begin
        nxt_pd_mode = wr_data_in[`OBD_WR_PD_MODE];
        nxt_pd_sel  = wr_data_in[`OBD_WR_PD_SEL];
      end else if (wr_op == `OBD_CMD_CLEAR) begin
        nxt_clr_sel = wr_data_in[`OBD_WR_CLEAR];
      end else if (wr_op == `OBD_CMD_OVERRIDE) begin
        nxt_ovr = wr_data_in[`OBD_WR_OVERRIDE];
      end else if (wr_op == `OBD_CMD_RESET) begin
        nxt_buf     = '{default: `OBD_CODE_RST};
        nxt_act     = '{default: `OBD_CODE_RST};
        nxt_pd_mode = `OBD_PD_MODE_RST;
        nxt_pd_sel  = `OBD_PD_SEL_RST;
        nxt_clr_sel = `OBD_CLEAR_RST;
        nxt_ovr     = `OBD_OVERRIDE_RST;
      end
    end
    // clear pin overrides a code write in the same cycle; power, clear and override writes still land
    if (clr_fall && clr_sel_ff != `OBD_CLR_OFF) begin
      for (int i = 0; i < `OBD_NUM_CH; i++) begin
        nxt_buf[i] = clear_value(clr_sel_ff);
        nxt_act[i] = clear_value(clr_sel_ff);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      buf_ff     <= '{default: `OBD_CODE_RST};
      act_ff     <= '{default: `OBD_CODE_RST};
      pd_mode_ff <= `OBD_PD_MODE_RST;
      pd_sel_ff  <= `OBD_PD_SEL_RST;
      clr_sel_ff <= `OBD_CLEAR_RST;
      ovr_ff     <= `OBD_OVERRIDE_RST;
    end else begin
      buf_ff     <= nxt_buf;
      act_ff     <= nxt_act;
      pd_mode_ff <= nxt_pd_mode;
      pd_sel_ff  <= nxt_pd_sel;
      clr_sel_ff <= nxt_clr_sel;
      ovr_ff     <= nxt_ovr;
    end
  end

  always_comb begin
    for (int i = 0; i < `OBD_NUM_CH; i++) begin
      active_code_out[i*`OBD_STORE_BITS +: `OBD_STORE_BITS] = act_ff[i];
    end
  end
  assign power_mode_out = pd_mode_ff;
  assign power_sel_out  = pd_sel_ff;

  // ********************************
  // readback decoder
  // ********************************
  obd_state_e  st_ff;
  obd_state_e  nxt_st;
  logic [15:0] word_ff;
  logic [15:0] nxt_word;
  logic        inv_ff;
  logic        nxt_inv;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [3:0]  cmd_op;
  logic [2:0]  cmd_ch;

  assign cmd_op = cmd_byte_in[7:4];
  assign cmd_ch = cmd_byte_in[2:0];

  always_comb begin
    nxt_st     = st_ff;
    nxt_word   = word_ff;
    nxt_inv    = inv_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    if (cmd_valid_in) begin
      // snapshot now so later writes cannot tear the two bytes
      nxt_st   = obd_st_msb;
      nxt_inv  = 1'b0;
      nxt_word = 16'h0000;
      if ((cmd_op == `OBD_CMD_INPUT || cmd_op == `OBD_CMD_ACTIVE) && cmd_byte_in[3]) begin
        nxt_inv = 1'b1;
      end else if (cmd_op == `OBD_CMD_INPUT) begin
        nxt_word = pack_code(buf_ff[cmd_ch]);
      end else if (cmd_op == `OBD_CMD_ACTIVE) begin
        nxt_word = pack_code(act_ff[cmd_ch]);
      end else if (cmd_op == `OBD_CMD_POWER) begin
        nxt_word = {6'h00, pd_mode_ff, pd_sel_ff};
      end else if (cmd_op == `OBD_CMD_CLEAR) begin
        nxt_word = {14'h0000, clr_sel_ff};
      end else if (cmd_op == `OBD_CMD_OVERRIDE) begin
        nxt_word = {8'h00, ovr_ff};
      end else begin
        nxt_inv = 1'b1;
      end
    end else if (rd_req_in) begin
      nxt_rvalid = 1'b1;
      case (st_ff)
        obd_st_msb: begin
          nxt_rdata = word_ff[15:8];
          nxt_st    = obd_st_lsb;
        end
        obd_st_lsb: begin
          nxt_rdata = word_ff[7:0];
          nxt_st    = obd_st_idle;
        end
        default: begin
          nxt_rdata = 8'h00;
          nxt_st    = obd_st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff     <= obd_st_idle;
      word_ff   <= 16'h0000;
      inv_ff    <= 1'b0;
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      word_ff   <= nxt_word;
      inv_ff    <= nxt_inv;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign rd_data_out  = rdata_ff;
  assign rd_valid_out = rvalid_ff;
  assign invalid_out  = inv_ff;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_cmd_taken;
    cmd_valid_in ##1 !cmd_valid_in && rd_req_in;
  endsequence

  sequence s_second_read;
    !cmd_valid_in && rd_req_in;
  endsequence

  a_input_readback: assert property (
    cmd_valid_in && cmd_op == `OBD_CMD_INPUT && !cmd_byte_in[3]
    |=> word_ff == pack_code($past(buf_ff[cmd_ch])) && !invalid_out)
    else $error("input buffer readback wrong");

  a_active_readback: assert property (
    cmd_valid_in && cmd_op == `OBD_CMD_ACTIVE && !cmd_byte_in[3]
    |=> word_ff == pack_code($past(act_ff[cmd_ch])) && !invalid_out)
    else $error("active code readback wrong");

  a_invalid_access: assert property (
    cmd_valid_in && cmd_op inside {`OBD_CMD_INPUT, `OBD_CMD_ACTIVE} && cmd_byte_in[3]
    |=> invalid_out && word_ff == 16'h0000)
    else $error("invalid access not flagged");

  a_msb_then_lsb: assert property (
    s_cmd_taken ##1 s_second_read
    |=> rd_valid_out && rd_data_out == $past(word_ff[7:0])
        && $past(rd_data_out, 1) == $past(word_ff[15:8]))
    else $error("byte order of readback wrong");

  a_low_bits_zero: assert property (
    cmd_valid_in && cmd_op inside {`OBD_CMD_INPUT, `OBD_CMD_ACTIVE}
    |=> word_ff[3+SHIFT:0] == '0)
    else $error("bits below the code not zero");

  a_power_readback: assert property (
    cmd_valid_in && cmd_op == `OBD_CMD_POWER
    |=> word_ff == {6'h00, $past(pd_mode_ff), $past(pd_sel_ff)})
    else $error("power register readback wrong");

  a_clear_readback: assert property (
    cmd_valid_in && cmd_op == `OBD_CMD_CLEAR |=> word_ff[15:2] == 14'h0000
    && word_ff[1:0] == $past(clr_sel_ff))
    else $error("clear register readback wrong");

  a_override_readback: assert property (
    cmd_valid_in && cmd_op == `OBD_CMD_OVERRIDE
    |=> word_ff == {8'h00, $past(ovr_ff)})
    else $error("override register readback wrong");

  a_override_hold: assert property (
    load_fall && !wr_valid_in && !clr_fall && ovr_ff[0]
    |=> act_ff[0] == $past(act_ff[0]))
    else $error("overridden channel followed load pin");

  a_load_follow: assert property (
    load_fall && !wr_valid_in && !clr_fall && !ovr_ff[7]
    |=> act_ff[7] == $past(buf_ff[7]))
    else $error("channel ignored load pin");

  a_power_write: assert property (
    wr_valid_in && wr_op == `OBD_CMD_POWER && !clr_fall
    |=> power_mode_out == $past(wr_data_in[14:13]))
    else $error("power mode not stored");

  a_clear_load: assert property (
    clr_fall && clr_sel_ff != `OBD_CLR_OFF
    |=> act_ff[7] == clear_value($past(clr_sel_ff)) ##1 1'b1)
    else $error("clear pin loaded wrong code");

  a_clear_off: assert property (
    clr_fall && clr_sel_ff == `OBD_CLR_OFF && !wr_valid_in && !load_fall
    |=> $stable(act_ff[7]) && $stable(buf_ff[7]))
    else $error("disabled clear pin acted");

endmodule

//--- inc/obd_defs.svh
// constants of the octal readback decoder: opcodes, field positions,
// reset values and packing widths; included by the package and the logic
`ifndef OBD_DEFS_SVH
`define OBD_DEFS_SVH

`define OBD_NUM_CH        8
`define OBD_CODE_BITS     12
`define OBD_STORE_BITS    12

// command nibble values
`define OBD_CMD_INPUT     4'h0
`define OBD_CMD_ACTIVE    4'h1
`define OBD_CMD_POWER     4'h4
`define OBD_CMD_CLEAR     4'h5
`define OBD_CMD_OVERRIDE  4'h6
`define OBD_CMD_RESET     4'h7

// write data field positions within the two data bytes
`define OBD_WR_PD_MODE    14:13
`define OBD_WR_PD_SEL     12:5
`define OBD_WR_CLEAR      5:4
`define OBD_WR_OVERRIDE   15:8

// clear-code selections
`define OBD_CLR_ZERO      2'h0
`define OBD_CLR_MID       2'h1
`define OBD_CLR_FULL      2'h2
`define OBD_CLR_OFF       2'h3

// power modes
`define OBD_PWR_ON        2'h0
`define OBD_PWR_1K        2'h1
`define OBD_PWR_100K      2'h2
`define OBD_PWR_HIZ       2'h3

// reset values
`define OBD_CODE_RST      12'h000
`define OBD_PD_MODE_RST   2'h0
`define OBD_PD_SEL_RST    8'h00
`define OBD_CLEAR_RST     2'h0
`define OBD_OVERRIDE_RST  8'h00
`define OBD_PIN_IDLE      1'b1

`endif

//--- inc/obd_pkg.sv
// types shared by the readback decoder files
// assumes obd_defs.svh is on the include path
`include "obd_defs.svh"

package obd_pkg;

  typedef enum logic [2:0] {
    obd_st_idle = 3'b001,
    obd_st_msb  = 3'b010,
    obd_st_lsb  = 3'b100
  } obd_state_e;

  typedef logic [`OBD_STORE_BITS-1:0] obd_code_t;

endpackage

//--- logic/obd_pin_fall.sv
// two-flop synchroniser with falling-edge pulse for an active-low pin
// assumes the pin is asynchronous to clk_in and idles high
`timescale 1ns/1ps
`include "obd_defs.svh"

module obd_pin_fall
  import obd_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_n_in,
  output logic      fall_out
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  always_comb begin
    nxt_meta = pin_n_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  // reset to idle level so release never looks like an edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_ff <= `OBD_PIN_IDLE;
      sync_ff <= `OBD_PIN_IDLE;
      last_ff <= `OBD_PIN_IDLE;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign fall_out = last_ff & ~sync_ff;

endmodule

//--- tb/obd_ctrl_model.sv
// bus controller model: sends a command byte, then clocks out data bytes
// assumes the readback port of one decoder and a free-running clk_in
`timescale 1ns/1ps

module obd_ctrl_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  output logic            cmd_valid_out,
  output logic [7:0]      cmd_byte_out,
  output logic            rd_req_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_byte_out  = 8'hff;
    rd_req_out    = 1'b0;
  end

  // hold keeps the request up so the next byte follows back to back
  task automatic read_byte(input logic hold, output logic [7:0] b, output logic ok);
    rd_req_out = 1'b1;
    @(negedge clk_in);
    b  = rd_data_in;
    ok = rd_valid_in;
    if (!hold) begin
      rd_req_out = 1'b0;
      @(negedge clk_in);
    end
  endtask

  // a nonzero gap gives gap+1 idle cycles between the bytes to model a slow controller
  task automatic read_word(input logic [7:0] cmd, input int gap,
                           output logic [15:0] w, output logic ok);
    logic ok_hi;
    cmd_valid_out = 1'b1;
    cmd_byte_out  = cmd;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    // released byte shows a changed pattern, not the last value
    cmd_byte_out  = ~cmd;
    read_byte(gap == 0, w[15:8], ok_hi);
    repeat (gap) @(negedge clk_in);
    read_byte(1'b0, w[7:0], ok);
    ok = ok & ok_hi;
  endtask
endmodule

//--- tb/obd_readback_tb_top.sv
// testbench: three decoder widths fed in parallel, read through the model
// assumes obd_readback and obd_ctrl_model are compiled first
`timescale 1ns/1ps

module obd_readback_tb_top;
  localparam int         CBS [3]      = '{12, 10, 8};
  localparam logic [7:0] BAD [6]      = '{8'h08, 8'h1f, 8'h20, 8'h37, 8'h7a, 8'hf0};
  localparam logic [15:0] CLR_EXP [4] = '{16'h0000, 16'h8000, 16'hffff, 16'hffff};

  logic        clk_in   = 1'b0;
  logic        rst_in   = 1'b1;
  logic        wr_valid = 1'b0;
  logic [7:0]  wr_cmd   = 8'h00;
  logic [15:0] wr_data  = 16'h0000;
  logic        load_n   = 1'b1;
  logic        clear_n  = 1'b1;
  logic        cmd_valid;
  logic [7:0]  cmd_byte;
  logic        rd_req;
  logic [7:0]  rd_data_w [3];
  logic        rd_valid_w [3];
  logic        invalid_w [3];
  logic [1:0]  pwr_mode_w [3];
  logic [7:0]  pwr_sel_w [3];
  logic [95:0] act_w [3];
  int          sel = 0;
  int          miscompares = 0;
  int          n_tests = 0;

  always #10 clk_in = ~clk_in;

  for (genvar g = 0; g < 3; g++) begin : g_width
    obd_readback #(.CODE_BITS(CBS[g])) obd_readback_inst (
      .clk_in(clk_in), .rst_in(rst_in),
      .cmd_valid_in(cmd_valid), .cmd_byte_in(cmd_byte), .rd_req_in(rd_req),
      .rd_data_out(rd_data_w[g]), .rd_valid_out(rd_valid_w[g]), .invalid_out(invalid_w[g]),
      .wr_valid_in(wr_valid), .wr_cmd_in(wr_cmd), .wr_data_in(wr_data),
      .load_trigger_pin_n_in(load_n), .clear_pin_n_in(clear_n),
      .active_code_out(act_w[g]), .power_mode_out(pwr_mode_w[g]), .power_sel_out(pwr_sel_w[g])
    );
  end

  obd_ctrl_model obd_ctrl_model_inst (
    .clk_in(clk_in), .rd_data_in(rd_data_w[sel]), .rd_valid_in(rd_valid_w[sel]),
    .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte), .rd_req_out(rd_req)
  );

  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    wr_valid = 1'b1;
    wr_cmd   = c;
    wr_data  = d;
    @(negedge clk_in);
    wr_valid = 1'b0;
    wr_cmd   = ~c;
    wr_data  = ~d;
    @(negedge clk_in);
  endtask

  // codes come back left-justified, so narrow widths lose the low bits
  task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic code,
                    input logic inv);
    logic [15:0] w;
    logic        ok;
    for (int s = 0; s < 3; s++) begin
      sel = s;
      obd_ctrl_model_inst.read_word(c, s, w, ok);
      chk_word(w, code ? exp & (16'hffff << (16 - CBS[s])) : exp);
      chk_bit(ok, 1'b1);
      chk_bit(invalid_w[s], inv);
    end
  endtask

  // low long enough for the two-flop synchroniser plus the edge
  task automatic pulse(input logic clr);
    if (clr) clear_n = 1'b0;
    else load_n = 1'b0;
    repeat (3) @(negedge clk_in);
    clear_n = 1'b1;
    load_n  = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic complete_run;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_in);
    miscompares++;
    complete_run();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    logic [15:0] d;
    logic [7:0]  b;
    logic        ok;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rd(8'h40, 16'h0000, 1'b0, 1'b0);
    rd(8'h57, 16'h0000, 1'b0, 1'b0);
    rd(8'h6f, 16'h0000, 1'b0, 1'b0);
    for (int ch = 0; ch < 8; ch++) begin
      d = 16'h1a50 + 16'(ch) * 16'h1110;
      wr({5'h00, 3'(ch)}, d);
      rd({5'h00, 3'(ch)}, d, 1'b1, 1'b0);
      rd({5'h02, 3'(ch)}, 16'h0000, 1'b1, 1'b0);
    end
    wr(8'h15, 16'hc3a5);
    rd(8'h15, 16'hc3a5, 1'b1, 1'b0);
    obd_ctrl_model_inst.read_byte(1'b0, b, ok);
    chk_word({8'h00, b}, 16'h0000);
    chk_bit(ok, 1'b1);
    for (int i = 0; i < 6; i++) rd(BAD[i], 16'h0000, 1'b0, 1'b1);
    rd(8'h03, 16'h4d80, 1'b1, 1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(8'h4f, {1'b0, 2'(m), 8'ha5 ^ 8'(m), 5'h00});
      rd(8'h4c, {6'h00, 2'(m), 8'ha5 ^ 8'(m)}, 1'b0, 1'b0);
      chk_word({14'h0, pwr_mode_w[0]}, 16'(m));
      chk_word({8'h00, pwr_sel_w[2]}, {8'h00, 8'ha5 ^ 8'(m)});
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h5a, {10'h000, 2'(c), 4'h0});
      rd(8'h53, {14'h0, 2'(c)}, 1'b0, 1'b0);
      pulse(1'b1);
      rd(8'h10, CLR_EXP[c], 1'b1, 1'b0);
    end
    wr(8'h60, 16'h0f00);
    rd(8'h6e, 16'h000f, 1'b0, 1'b0);
    wr(8'h00, 16'h5a50);
    wr(8'h07, 16'h6b60);
    pulse(1'b0);
    rd(8'h10, 16'hffff, 1'b1, 1'b0);
    rd(8'h17, 16'h6b60, 1'b1, 1'b0);
    // channel outputs: right-aligned codes, 12-bit field per channel
    chk_word({4'h0, act_w[0][95:84]}, 16'h06b6);
    chk_word({4'h0, act_w[2][11:0]}, 16'h00ff);
    // software reset opcode brings every register back to its default
    wr(8'h70, 16'h0000);
    rd(8'h40, 16'h0000, 1'b0, 1'b0);
    rd(8'h6f, 16'h0000, 1'b0, 1'b0);
    rd(8'h17, 16'h0000, 1'b1, 1'b0);
    complete_run();
  end
endmodule
